// *** inc/tpg_pkg.sv ***
// Package of constants and carrier types for the two-port GPIO block.
package tpg_pkg;

  // ==========================================================================
  // Register offsets on the special-function-register bus
  localparam logic [7:0] TPG_PORT_ZERO_DATA_ADDR = 8'h80;
  localparam logic [7:0] TPG_PORT_ONE_DATA_ADDR = 8'h90;
  // Bit-address space: bit address = port base + pin number.
  localparam logic [7:0] TPG_BIT_ADDR_MASK = 8'hf8;
  localparam logic [2:0] TPG_BIT_IDX_MASK = 3'h7;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] TPG_LATCH_RESET = 8'hff;
  localparam logic [7:0] TPG_MASK_RESET = 8'h00;
  localparam logic [7:0] TPG_COMPARE_RESET = 8'hff;

  // ==========================================================================
  // Register bus access
  typedef enum logic [1:0] {
    TPG_OP_IDLE = 2'b00,
    TPG_OP_READ = 2'b01,
    TPG_OP_WRITE = 2'b10
  } tpg_op_t;

  typedef struct packed {
    tpg_op_t op;      // Read or write strobe, one cycle.
    logic bit_mode;   // Access targets one bit, not the byte.
    logic rmw;        // Read is the read phase of a read-modify-write.
    logic [7:0] addr; // Byte address, or bit address in bit mode.
    logic [7:0] wdata;// Write byte; bit 0 is the value in bit mode.
  } tpg_sfr_req_t;

  typedef struct packed {
    logic [7:0] first_port_compare_mask;
    logic [7:0] first_port_compare_value;
    logic [7:0] second_port_compare_mask;
    logic [7:0] second_port_compare_value;
  } tpg_match_cfg_t;

endpackage

// *** hw/tpg_gpio.sv ***
// Two 8-bit general purpose ports with pattern-match event.
`timescale 1ns/1ps

module tpg_gpio #(
  parameter int WIDTH = 8
) (
  input wire logic clock_in,                        // System clock, 40 MHz.
  input wire logic reset_n_in,                      // Async reset, active low.
  input wire tpg_pkg::tpg_sfr_req_t sfr_req_in,     // Register bus request.
  input wire logic match_irq_enable_in,             // Match interrupt enable.
  input wire tpg_pkg::tpg_match_cfg_t match_cfg_in, // Mask and compare values.
  input wire logic [WIDTH-1:0] first_port_pins_in,  // First port pin levels.
  input wire logic [WIDTH-1:0] second_port_pins_in, // Second port pin levels.
  output logic [WIDTH-1:0] first_port_latch_out,    // First port output latch.
  output logic [WIDTH-1:0] second_port_latch_out,   // Second port latch.
  output logic [WIDTH-1:0] sfr_rdata_out,           // Read data.
  output logic sfr_rvalid_out,                      // Read data valid pulse.
  output logic match_out,                           // Match event level.
  output logic match_irq_out,                       // Match interrupt request.
  output logic wake_out                             // Oscillator wake request.
);

  // ==========================================================================
  // Pin sampling
  // Pins are taken as synchronous, so one register stage suffices; match and
  // reads both see the same sampled value.
  logic [WIDTH-1:0] pins0_reg, pins0_next;
  logic [WIDTH-1:0] pins1_reg, pins1_next;
  logic [WIDTH-1:0] latch0_reg, latch0_next;
  logic [WIDTH-1:0] latch1_reg, latch1_next;
  logic [WIDTH-1:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic match_reg, match_next;
  logic irq_reg, irq_next;
  logic wake_reg, wake_next;

  logic hit0, hit1, bit_hit0, bit_hit1;
  logic [2:0] bit_idx;
  logic [WIDTH-1:0] pin_view, latch_view;
  logic mis0, mis1;

  always_comb begin
    pins0_next = first_port_pins_in;
    pins1_next = second_port_pins_in;
  end

  // ==========================================================================
  // Register bus decode
  always_comb begin
    bit_idx = sfr_req_in.addr[2:0] & tpg_pkg::TPG_BIT_IDX_MASK;
    hit0 = !sfr_req_in.bit_mode &&
           sfr_req_in.addr == tpg_pkg::TPG_PORT_ZERO_DATA_ADDR;
    hit1 = !sfr_req_in.bit_mode &&
           sfr_req_in.addr == tpg_pkg::TPG_PORT_ONE_DATA_ADDR;
    bit_hit0 = sfr_req_in.bit_mode &&
               (sfr_req_in.addr & tpg_pkg::TPG_BIT_ADDR_MASK) ==
               tpg_pkg::TPG_PORT_ZERO_DATA_ADDR;
    bit_hit1 = sfr_req_in.bit_mode &&
               (sfr_req_in.addr & tpg_pkg::TPG_BIT_ADDR_MASK) ==
               tpg_pkg::TPG_PORT_ONE_DATA_ADDR;
  end

  // ==========================================================================
  // Output latches
  always_comb begin
    latch0_next = latch0_reg;
    latch1_next = latch1_reg;
    if (sfr_req_in.op == tpg_pkg::TPG_OP_WRITE) begin
      if (hit0) begin
        latch0_next = sfr_req_in.wdata[WIDTH-1:0];
      end
      if (hit1) begin
        latch1_next = sfr_req_in.wdata[WIDTH-1:0];
      end
      if (bit_hit0) begin
        latch0_next[bit_idx] = sfr_req_in.wdata[0];
      end
      if (bit_hit1) begin
        latch1_next[bit_idx] = sfr_req_in.wdata[0];
      end
    end
  end

  // ==========================================================================
  // Read path
  always_comb begin
    pin_view = '0;
    latch_view = '0;
    if (hit0 || bit_hit0) begin
      pin_view = pins0_reg;
      latch_view = latch0_reg;
    end else if (hit1 || bit_hit1) begin
      pin_view = pins1_reg;
      latch_view = latch1_reg;
    end
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    if (sfr_req_in.op == tpg_pkg::TPG_OP_READ) begin
      rvalid_next = 1'b1;
      rdata_next = pin_view;
      if (sfr_req_in.rmw) begin
        rdata_next = latch_view;
      end
      if (sfr_req_in.bit_mode) begin
        rdata_next = '0;
        rdata_next[0] = sfr_req_in.rmw ? latch_view[bit_idx]
                                       : pin_view[bit_idx];
      end
      if (!(hit0 || hit1 || bit_hit0 || bit_hit1)) begin
        rdata_next = '0;
      end
    end
  end

  // ==========================================================================
  // Match detection
  always_comb begin
    mis0 = (pins0_reg & match_cfg_in.first_port_compare_mask) !=
           (match_cfg_in.first_port_compare_value &
            match_cfg_in.first_port_compare_mask);
    mis1 = (pins1_reg & match_cfg_in.second_port_compare_mask) !=
           (match_cfg_in.second_port_compare_value &
            match_cfg_in.second_port_compare_mask);
    match_next = mis0 || mis1;
    irq_next = (mis0 || mis1) && match_irq_enable_in;
    wake_next = mis0 || mis1;
  end

  // ==========================================================================
  // State registers
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pins0_reg <= '0;
      pins1_reg <= '0;
      latch0_reg <= tpg_pkg::TPG_LATCH_RESET;
      latch1_reg <= tpg_pkg::TPG_LATCH_RESET;
      rdata_reg <= '0;
      rvalid_reg <= 1'b0;
      match_reg <= 1'b0;
      irq_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      pins0_reg <= pins0_next;
      pins1_reg <= pins1_next;
      latch0_reg <= latch0_next;
      latch1_reg <= latch1_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      match_reg <= match_next;
      irq_reg <= irq_next;
      wake_reg <= wake_next;
    end
  end

  assign first_port_latch_out = latch0_reg;
  assign second_port_latch_out = latch1_reg;
  assign sfr_rdata_out = rdata_reg;
  assign sfr_rvalid_out = rvalid_reg;
  assign match_out = match_reg;
  assign match_irq_out = irq_reg;
  assign wake_out = wake_reg;

  // ==========================================================================
  // Checks
  // byte write lands
  AST_LATCH_WRITE: assert property (
    @(posedge clock_in) disable iff (!reset_n_in)
    sfr_req_in.op == tpg_pkg::TPG_OP_WRITE && hit0
    |=> first_port_latch_out == $past(sfr_req_in.wdata))
    else $error("byte write not latched");
  AST_LATCH_HOLD: assert property (
    @(posedge clock_in) disable iff (!reset_n_in)
    sfr_req_in.op != tpg_pkg::TPG_OP_WRITE |=> $stable(first_port_latch_out))
    else $error("latch changed without write");
  AST_BIT_WRITE: assert property (
    @(posedge clock_in) disable iff (!reset_n_in)
    sfr_req_in.op == tpg_pkg::TPG_OP_WRITE && bit_hit1
    |=> second_port_latch_out[$past(bit_idx)] == $past(sfr_req_in.wdata[0]))
    else $error("bit write not latched");
  AST_PIN_READ: assert property (
    @(posedge clock_in) disable iff (!reset_n_in)
    sfr_req_in.op == tpg_pkg::TPG_OP_READ && hit0 && !sfr_req_in.rmw
    |=> sfr_rvalid_out && sfr_rdata_out == $past(pins0_reg))
    else $error("read did not return pins");
  AST_RMW_READ: assert property (
    @(posedge clock_in) disable iff (!reset_n_in)
    sfr_req_in.op == tpg_pkg::TPG_OP_READ && hit1 && sfr_req_in.rmw
    |=> sfr_rdata_out == $past(latch1_reg))
    else $error("rmw read did not return latch");
  AST_MATCH: assert property (
    @(posedge clock_in) disable iff (!reset_n_in)
    ##1 match_out == $past(mis0 || mis1))
    else $error("match level wrong");
  AST_IRQ_GATE: assert property (
    @(posedge clock_in) disable iff (!reset_n_in)
    match_irq_out |-> $past(match_irq_enable_in) && match_out)
    else $error("interrupt without enable");
  AST_WAKE: assert property (
    @(posedge clock_in) disable iff (!reset_n_in)
    wake_out == match_out)
    else $error("wake does not follow match");

endmodule // tpg_gpio

// *** sim/tpg_pins_model.sv ***
// External pin model: latch drive with some pins taken by other peripherals.
`timescale 1ns/1ps
module tpg_pins_model (
  input wire logic [7:0] latch0_in,   // First port output latch.
  input wire logic [7:0] latch1_in,   // Second port output latch.
  input wire logic [15:0] ovr_en_in,  // Pins claimed by other peripherals.
  input wire logic [15:0] ovr_val_in, // Levels those peripherals drive.
  output logic [7:0] pins0_out,       // First port pin levels.
  output logic [7:0] pins1_out        // Second port pin levels.
);
  // A claimed pin follows its peripheral, so pin and latch can disagree.
  assign pins0_out = (latch0_in & ~ovr_en_in[7:0]) |
                     (ovr_val_in[7:0] & ovr_en_in[7:0]);
  assign pins1_out = (latch1_in & ~ovr_en_in[15:8]) |
                     (ovr_val_in[15:8] & ovr_en_in[15:8]);
endmodule // tpg_pins_model

// *** sim/tpg_gpio_bench.sv ***
// Self-checking bench for the two-port GPIO block.
`timescale 1ns/1ps
module tpg_gpio_bench;
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  tpg_pkg::tpg_sfr_req_t req = '0;
  logic irq_en = 1'b0;
  tpg_pkg::tpg_match_cfg_t cfg = '0;
  logic [15:0] ovr_en = '0;
  logic [15:0] ovr_val = '0;
  logic [7:0] port0_pins, port1_pins, lat0, lat1, rdata;
  logic rvalid, match, irq, wake;
  logic [7:0] lat [2];
  logic [31:0] seed = 32'h39;
  logic [31:0] r;
  logic [7:0] a, pv;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;

  always #12.5 clock_in = ~clock_in;

  tpg_gpio dut (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .sfr_req_in(req), .match_irq_enable_in(irq_en), .match_cfg_in(cfg),
    .first_port_pins_in(port0_pins), .second_port_pins_in(port1_pins),
    .first_port_latch_out(lat0), .second_port_latch_out(lat1),
    .sfr_rdata_out(rdata), .sfr_rvalid_out(rvalid), .match_out(match),
    .match_irq_out(irq), .wake_out(wake));

  tpg_pins_model pins (.latch0_in(lat0), .latch1_in(lat1),
    .ovr_en_in(ovr_en), .ovr_val_in(ovr_val),
    .pins0_out(port0_pins), .pins1_out(port1_pins));

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] pin_lvl(int p);
    return (lat[p] & ~ovr_en[p*8+:8]) | (ovr_val[p*8+:8] & ovr_en[p*8+:8]);
  endfunction

  function automatic logic exp_match();
    return ((pin_lvl(0) & cfg.first_port_compare_mask) !=
            (cfg.first_port_compare_value & cfg.first_port_compare_mask)) ||
           ((pin_lvl(1) & cfg.second_port_compare_mask) !=
            (cfg.second_port_compare_value & cfg.second_port_compare_mask));
  endfunction

  task automatic results();
    if (mismatches == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // The strobe lasts one cycle; results are sampled after the taking edge.
  task automatic access(input tpg_pkg::tpg_op_t op, input logic bm,
                        input logic rmw, input logic [7:0] ad,
                        input logic [7:0] wd);
    @(posedge clock_in);
    req <= '{op, bm, rmw, ad, wd};
    @(posedge clock_in);
    req.op <= tpg_pkg::TPG_OP_IDLE;
    #1;
  endtask

  task automatic rd(input logic bm, input logic rmw, input logic [7:0] ad,
                    input logic [7:0] exp);
    access(tpg_pkg::TPG_OP_READ, bm, rmw, ad, 8'h00);
    check({7'h00, rvalid}, 8'h01);
    check(rdata, exp);
  endtask

  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      results();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clock_in);
    reset_n_in <= 1'b1;
    lat[0] = tpg_pkg::TPG_LATCH_RESET;
    lat[1] = tpg_pkg::TPG_LATCH_RESET;
    #1;
    check(lat0, lat[0]);
    check(lat1, lat[1]);
    rd(1'b0, 1'b0, 8'ha0, 8'h00);
    // An unmapped write must leave both latches alone.
    access(tpg_pkg::TPG_OP_WRITE, 1'b0, 1'b0, 8'ha0, 8'h00);
    check(lat0, lat[0]);
    check(lat1, lat[1]);
    for (int i = 0; i < 40; i++) begin
      a = (i % 2) ? tpg_pkg::TPG_PORT_ONE_DATA_ADDR
                  : tpg_pkg::TPG_PORT_ZERO_DATA_ADDR;
      r = rnd();
      access(tpg_pkg::TPG_OP_WRITE, 1'b0, 1'b0, a, r[7:0]);
      lat[i % 2] = r[7:0];
      check((i % 2) ? lat1 : lat0, lat[i % 2]);
      r = rnd();
      @(posedge clock_in);
      // The first passes hand every pin to other peripherals.
      // Pass 7 sets full masks equal to the driven pins: no event expected.
      ovr_en <= (i < 4) ? 16'hffff : (i == 7) ? 16'h0000 : r[15:0];
      ovr_val <= r[31:16];
      if (i == 7)
        cfg <= tpg_tpg_cfg({8'hff, lat[0], 8'hff, lat[1]});
      else
        cfg <= tpg_tpg_cfg((i == 5) ? 32'h0 : rnd());
      irq_en <= r[3];
      repeat (4) @(posedge clock_in);
      #1;
      check({7'h00, match}, {7'h00, exp_match()});
      check({7'h00, irq}, {7'h00, exp_match() & irq_en});
      check({7'h00, wake}, {7'h00, exp_match()});
      rd(1'b0, 1'b0, a, pin_lvl(i % 2));
      rd(1'b0, 1'b1, a, lat[i % 2]);
      access(tpg_pkg::TPG_OP_WRITE, 1'b1, 1'b0, a | r[6:4], {7'h00, r[7]});
      lat[i % 2][r[6:4]] = r[7];
      check((i % 2) ? lat1 : lat0, lat[i % 2]);
      rd(1'b1, 1'b1, a | r[6:4], {7'h00, lat[i % 2][r[6:4]]});
      pv = pin_lvl(i % 2);
      rd(1'b1, 1'b0, a | r[6:4], {7'h00, pv[r[6:4]]});
    end
    results();
  end

  function automatic tpg_pkg::tpg_match_cfg_t tpg_tpg_cfg(logic [31:0] v);
    return tpg_pkg::tpg_match_cfg_t'(v);
  endfunction
endmodule // tpg_gpio_bench
